/* File: core/djk_dual_ff.sv */
// dual falling-edge j-k flip-flop with direct clear
//
// Functional notes
// - two independent flip-flops, sharing only clk_sys and sys_rst
// - each has a clock-independent direct clear
// - steering taken only at a falling edge, sampled with the first low clock sample
// - hold, set, clear, toggle per steering pair
// - complement output always inverse of true
// - toggle mode gives half clock frequency
`timescale 1ns/1ps
module djk_dual_ff
  import djk_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      sys_rst,
  input  wire logic [djk_pkg::NUM_FF-1:0] steer_set,
  input  wire logic [djk_pkg::NUM_FF-1:0] steer_clr,
  input  wire logic [djk_pkg::NUM_FF-1:0] ff_clk,
  input  wire logic [djk_pkg::NUM_FF-1:0] direct_clr,
  output logic      [djk_pkg::NUM_FF-1:0] q,
  output logic      [djk_pkg::NUM_FF-1:0] q_n
);
  import djk_pkg::*;

  djk_state_s st;
  djk_state_s next_st;
  logic [NUM_FF-1:0] fall;

  always_comb
  begin
    next_st           = st;
    next_st.set_meta  = steer_set;
    next_st.set_sync  = st.set_meta;
    next_st.clr_meta  = steer_clr;
    next_st.clr_sync  = st.clr_meta;
    next_st.clk_meta  = ff_clk;
    next_st.clk_sync  = st.clk_meta;
    next_st.clk_prev  = st.clk_sync;
    next_st.dclr_meta = direct_clr;
    next_st.dclr_sync = st.dclr_meta;
    fall = st.clk_prev & ~st.clk_sync;
    for (int i = 0; i < NUM_FF; i++)
    begin
      if (st.dclr_sync[i])
      begin
        next_st.q[i] = Q_RESET;
      end
      else if (fall[i])
      begin
        unique case ({st.set_sync[i], st.clr_sync[i]})
          STEER_HOLD:   next_st.q[i] = st.q[i];
          STEER_SET:    next_st.q[i] = 1'h1;
          STEER_CLEAR:  next_st.q[i] = 1'h0;
          STEER_TOGGLE: next_st.q[i] = ~st.q[i];
        endcase
      end
    end
    next_st.q_n = ~next_st.q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st     <= '0;
      st.q   <= {NUM_FF{Q_RESET}};
      st.q_n <= {NUM_FF{QN_RESET}};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q   = st.q;
  assign q_n = st.q_n;

  for (genvar g = 0; g < NUM_FF; g++)
  begin : g_chk
    chk_comp_inverse : assert property (@(posedge clk_sys) disable iff (sys_rst)
      st.q_n[g] == ~st.q[g])
      else $error("complement output not inverse of true output");

    chk_clear_forces : assert property (@(posedge clk_sys) disable iff (sys_rst)
      st.dclr_sync[g] |=> (!st.q[g] && st.q_n[g]))
      else $error("direct clear did not force outputs");

    chk_clear_pin_path : assert property (@(posedge clk_sys) disable iff (sys_rst)
      direct_clr[g] ##1 direct_clr[g] ##1 direct_clr[g] |=> !st.q[g])
      else $error("held direct clear did not reach output");

    chk_hold_state : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && st.set_sync[g] && st.clr_sync[g] |=> $stable(st.q[g]))
      else $error("hold pair changed the state");

    chk_set_state : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && st.set_sync[g] && !st.clr_sync[g] |=> st.q[g])
      else $error("set pair did not set the state");

    chk_clr_state : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && !st.set_sync[g] && st.clr_sync[g] |=> !st.q[g])
      else $error("clear pair did not clear the state");

    chk_toggle_half : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && !st.set_sync[g] && !st.clr_sync[g] |=> st.q[g] != $past(st.q[g]))
      else $error("toggle pair did not invert the state");

    chk_no_rise_change : assert property (@(posedge clk_sys) disable iff (sys_rst)
      !fall[g] && !st.dclr_sync[g] |=> $stable(st.q[g]))
      else $error("state changed without a falling clock edge");

    chk_clear_blocks_fall : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && st.dclr_sync[g]
      |=> !st.q[g] && st.q_n[g])
      else $error("clock edge got through a direct clear");

    chk_clear_held_low : assert property (@(posedge clk_sys) disable iff (sys_rst)
      st.dclr_sync[g] ##1 st.dclr_sync[g]
      |-> !st.q[g] && st.q_n[g])
      else $error("output rose while direct clear was held");

    chk_clear_release : assert property (@(posedge clk_sys) disable iff (sys_rst)
      st.dclr_sync[g] ##1 (!st.dclr_sync[g] && !fall[g])
      |=> !st.q[g])
      else $error("output left zero after clear release without a clock fall");

    chk_clear_pin_comp : assert property (@(posedge clk_sys) disable iff (sys_rst)
      direct_clr[g] [*3]
      |=> st.q_n[g])
      else $error("held direct clear did not raise the complement");

    chk_clear_sync_depth : assert property (@(posedge clk_sys) disable iff (sys_rst)
      st.dclr_sync[g]
      |-> $past(direct_clr[g], 2))
      else $error("direct clear skipped its synchroniser");

    chk_fall_sync_depth : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g]
      |-> $past(ff_clk[g], 3) && !$past(ff_clk[g], 2))
      else $error("clock fall seen without a synchronised pin fall");

    chk_steer_taken : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g]
      |-> st.set_sync[g] == $past(steer_set[g], 2) && st.clr_sync[g] == $past(steer_clr[g], 2))
      else $error("steering not taken from before the clock fall");

    chk_rise_no_effect : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(ff_clk[g]) ##2 !st.dclr_sync[g]
      |=> $stable(st.q[g]))
      else $error("rising clock pin changed the state");

    chk_own_pins_only : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(st.q[g]) && !$past(sys_rst)
      |-> $past(fall[g] || st.dclr_sync[g]))
      else $error("state changed without its own clock or clear");

    chk_set_from_pin : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(ff_clk[g]) && !$past(sys_rst) ##2 !st.dclr_sync[g] && st.set_sync[g] && !st.clr_sync[g]
      |=> st.q[g])
      else $error("set pair did not set on a clock pin fall");

    chk_clr_from_pin : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(ff_clk[g]) && !$past(sys_rst) ##2 !st.dclr_sync[g] && !st.set_sync[g] && st.clr_sync[g]
      |=> !st.q[g])
      else $error("clear pair did not clear on a clock pin fall");

    chk_hold_from_pin : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(ff_clk[g]) && !$past(sys_rst) ##2 !st.dclr_sync[g] && st.set_sync[g] && st.clr_sync[g]
      |=> $stable(st.q[g]))
      else $error("hold pair changed on a clock pin fall");

    chk_toggle_from_pin : assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(ff_clk[g]) && !$past(sys_rst) ##2 !st.dclr_sync[g] && !st.set_sync[g] && !st.clr_sync[g]
      |=> $changed(st.q[g]))
      else $error("toggle pair did not flip on a clock pin fall");

    chk_set_comp : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && st.set_sync[g] && !st.clr_sync[g]
      |=> !st.q_n[g])
      else $error("set pair left the complement high");

    chk_clr_comp : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && !st.set_sync[g] && st.clr_sync[g]
      |=> st.q_n[g])
      else $error("clear pair left the complement low");

    chk_hold_comp : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && st.set_sync[g] && st.clr_sync[g]
      |=> $stable(st.q_n[g]))
      else $error("hold pair changed the complement");

    chk_toggle_comp : assert property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.dclr_sync[g] && !st.set_sync[g] && !st.clr_sync[g]
      |=> st.q_n[g] == $past(st.q[g]))
      else $error("toggle pair gave a wrong complement");

    chk_port_inverse : assert property (@(posedge clk_sys) disable iff (sys_rst)
      q_n[g] == ~q[g])
      else $error("complement pin not inverse of true pin");

    cov_toggle : cover property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.set_sync[g] && !st.clr_sync[g] && !st.dclr_sync[g]);
    cov_set : cover property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && st.set_sync[g] && !st.clr_sync[g] && !st.dclr_sync[g]);
    cov_clear_high : cover property (@(posedge clk_sys) disable iff (sys_rst)
      st.q[g] ##1 st.dclr_sync[g] ##1 !st.q[g]);
    cov_hold : cover property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && st.set_sync[g] && st.clr_sync[g] && !st.dclr_sync[g]);
    cov_clear_pair : cover property (@(posedge clk_sys) disable iff (sys_rst)
      fall[g] && !st.set_sync[g] && st.clr_sync[g] && !st.dclr_sync[g]);
  end
endmodule : djk_dual_ff

/* File: core/djk_pkg.sv */
// shared constants and state type for the dual j-k flip-flop
package djk_pkg;
  localparam int unsigned NUM_FF   = 2;
  localparam logic        Q_RESET  = 1'h0;
  localparam logic        QN_RESET = 1'h1;

  // steering pair codes {set, clear}
  localparam logic [1:0] STEER_TOGGLE = 2'h0;
  localparam logic [1:0] STEER_CLEAR  = 2'h1;
  localparam logic [1:0] STEER_SET    = 2'h2;
  localparam logic [1:0] STEER_HOLD   = 2'h3;

  typedef struct packed {
    logic [NUM_FF-1:0] set_meta;
    logic [NUM_FF-1:0] set_sync;
    logic [NUM_FF-1:0] clr_meta;
    logic [NUM_FF-1:0] clr_sync;
    logic [NUM_FF-1:0] clk_meta;
    logic [NUM_FF-1:0] clk_sync;
    logic [NUM_FF-1:0] clk_prev;
    logic [NUM_FF-1:0] dclr_meta;
    logic [NUM_FF-1:0] dclr_sync;
    logic [NUM_FF-1:0] q;
    logic [NUM_FF-1:0] q_n;
  } djk_state_s;
endpackage : djk_pkg

/* File: test/djk_drv.sv */
// partner logic pulsing one flip-flop clock
`timescale 1ns/1ps
module djk_drv
  import djk_pkg::*;
(
  input  wire logic                      clk_sys,
  output logic      [djk_pkg::NUM_FF-1:0] ff_clk,
  output logic      [djk_pkg::NUM_FF-1:0] direct_clr
);
  import djk_pkg::*;
  initial ff_clk = '0;
  initial direct_clr = '0;
  task automatic op(input int i, input logic dc);
    direct_clr[i] <= dc;
    repeat (4) @(posedge clk_sys);
    ff_clk[i] <= 1'h1;
    repeat (4) @(posedge clk_sys);
    ff_clk[i] <= 1'h0;
    repeat (7) @(posedge clk_sys);
  endtask : op
endmodule : djk_drv

/* File: test/djk_dual_ff_tb.sv */
// self-checking bench for the dual flip-flop
`timescale 1ns/1ps
module djk_dual_ff_tb;
  import djk_pkg::*;
  logic              clk_sys = 1'h0;
  logic              sys_rst = 1'h1;
  logic [NUM_FF-1:0] steer_set = '0;
  logic [NUM_FF-1:0] steer_clr = '0;
  logic [NUM_FF-1:0] ff_clk, direct_clr, q, q_n;
  logic [NUM_FF-1:0] m = '0;
  logic [2*NUM_FF-1:0] exp_q[$];
  int                miscompares = 0;
  int                samples_checked = 0;
  event              look;
  djk_dual_ff i_djk_dual_ff (.clk_sys(clk_sys), .sys_rst(sys_rst), .steer_set(steer_set),
    .steer_clr(steer_clr), .ff_clk(ff_clk), .direct_clr(direct_clr), .q(q), .q_n(q_n));
  djk_drv i_djk_drv (.clk_sys(clk_sys), .ff_clk(ff_clk), .direct_clr(direct_clr));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(look)
  begin
    samples_checked++;
    if ({q, q_n} !== exp_q.pop_front())
    begin
      miscompares++;
      $display("[ERR] %0t output pair mismatch", $time);
    end
  end
  initial
  begin
    int         i;
    logic [1:0] c;
    logic       dc;
    void'($urandom(32'h2CFFE9CE));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    exp_q.push_back({{NUM_FF{Q_RESET}}, {NUM_FF{QN_RESET}}});
    -> look;
    repeat (60)
    begin
      i = $urandom_range(NUM_FF - 1, 0);
      c = 2'($urandom);
      dc = ($urandom_range(7, 0) == 0);
      steer_set[i] <= c[1];
      steer_clr[i] <= c[0];
      m[i] = m[i] & ~dc;
      exp_q.push_back({m, ~m});
      fork
        i_djk_drv.op(i, dc);
        begin
          repeat (8) @(posedge clk_sys);
          -> look;
        end
      join
      m[i] = dc ? 1'h0 : (c == STEER_HOLD) ? m[i] : (c == STEER_TOGGLE) ? ~m[i] : c[1];
      exp_q.push_back({m, ~m});
      -> look;
    end
    test_done();
  end
  initial
  begin
    #50us;
    miscompares++;
    test_done();
  end
endmodule : djk_dual_ff_tb
